// >>> shared/abc_consts.svh
// Constants for the AND-with-file and bit-clear execution block.
// Assumes a core that walks four quarter phases per instruction cycle.
`ifndef ABC_CONSTS_SVH
`define ABC_CONSTS_SVH
`define ABC_AND_TOP     7'h05
`define ABC_BITCLR_TOP  5'h11
`define ABC_D_BIT       8
`define ABC_FADDR_LSB   0
`define ABC_BIDX_LSB    8
`define ABC_W_RESET     8'h00
`define ABC_Z_RESET     1'b0
`endif

// >>> shared/abc_pkg.sv
// Types for the AND-with-file and bit-clear execution block.
// Shared by the datapath and its quarter-phase sequencer.
package abc_pkg;
    typedef enum logic [1:0] {ABC_Q1, ABC_Q2, ABC_Q3, ABC_Q4} abc_phase_e;
    typedef enum logic [1:0] {
        ABC_OP_NONE,
        ABC_OP_AND,
        ABC_OP_BITCLR
    } abc_op_e;
    typedef struct packed {
        abc_op_e    op;
        logic [7:0] faddr;
        logic [2:0] bidx;
        logic       dest_file;
    } abc_dec_s;
    typedef struct packed {
        logic       we;
        logic [7:0] addr;
        logic [7:0] data;
    } abc_fwr_s;
endpackage

// >>> rtl/abc_phase_seq.sv
// Quarter-phase sequencer: steps Q1..Q4 and wraps every cycle.
// Assumes rstn is synchronous to clock.
`timescale 1ns/1ps
module abc_phase_seq
    import abc_pkg::*;
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rstn,
    // Phase
    output abc_phase_e      phase
);
    abc_phase_e phase_reg;
    abc_phase_e phase_next;

    always_comb begin
        case (phase_reg)
            ABC_Q1:  phase_next = ABC_Q2;
            ABC_Q2:  phase_next = ABC_Q3;
            ABC_Q3:  phase_next = ABC_Q4;
            default: phase_next = ABC_Q1;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            phase_reg <= ABC_Q1;
        end else begin
            phase_reg <= phase_next;
        end
    end

    assign phase = phase_reg;
endmodule

// >>> rtl/abc_exec.sv
// Execution datapath for AND-with-file and bit-clear-file.
// Assumes the register file answers a read request in the same quarter
// phase it is asked (combinational read), and that the instruction word
// is stable from Q1 to Q4 of its cycle.
`timescale 1ns/1ps
`include "abc_consts.svh"
module abc_exec
    import abc_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // Instruction from decoder
    input  wire logic        instr_valid,
    input  wire logic [15:0] instr,
    // File register read port
    output logic [7:0]       file_raddr,
    input  wire logic [7:0]  file_rdata,
    // File register write port
    output logic             file_we,
    output logic [7:0]       file_waddr,
    output logic [7:0]       file_wdata,
    // Core state
    output logic [7:0]       working_register,
    output logic             zero_flag,
    output logic [1:0]       phase,
    output logic             busy_and
);
    function automatic logic [7:0] clear_bit(input logic [7:0] v,
                                             input logic [2:0] b);
        logic [7:0] m;
        m = 8'h01 << b;
        clear_bit = v & ~m;
    endfunction

    abc_phase_e q;
    abc_dec_s   dec_reg;
    abc_dec_s   dec_next;
    abc_fwr_s   fwr_reg;
    abc_fwr_s   fwr_next;
    logic [7:0] raddr_reg;
    logic [7:0] opnd_reg;
    logic [7:0] res_reg;
    logic [7:0] res_next;
    logic [7:0] w_reg;
    logic [7:0] w_next;
    logic       z_reg;
    logic       z_next;
    logic [1:0] ph_reg;
    logic       busy_reg;

    wire is_and = instr[15:9] == `ABC_AND_TOP;
    wire is_bitclr = instr[15:11] == `ABC_BITCLR_TOP;
    wire abc_op_e dec_op = !instr_valid ? ABC_OP_NONE :
                           is_and ? ABC_OP_AND :
                           is_bitclr ? ABC_OP_BITCLR : ABC_OP_NONE;

    abc_phase_seq u_seq (
        .clock (clock),
        .rstn  (rstn),
        .phase (q)
    );

    // Q1 decode: fields straight from the instruction word
    always_comb begin
        dec_next = dec_reg;
        if (q == ABC_Q1) begin
            dec_next.op        = dec_op;
            dec_next.faddr     = instr[`ABC_FADDR_LSB +: 8];
            dec_next.bidx      = instr[`ABC_BIDX_LSB +: 3];
            dec_next.dest_file = instr[`ABC_D_BIT];
        end
    end

    // Q3 execute
    wire [7:0] and_res = w_reg & opnd_reg;
    wire [7:0] clr_res = clear_bit(opnd_reg, dec_reg.bidx);
    always_comb begin
        res_next = res_reg;
        if (q == ABC_Q3) begin
            res_next = (dec_reg.op == ABC_OP_BITCLR) ? clr_res : and_res;
        end
    end

    // Q4 write; only AND touches Z, bit clear changes no flag
    wire wr_ph   = q == ABC_Q4;
    wire and_to_w = wr_ph && dec_reg.op == ABC_OP_AND &&
                    !dec_reg.dest_file;
    wire and_to_f = wr_ph && dec_reg.op == ABC_OP_AND &&
                    dec_reg.dest_file;
    wire clr_to_f = wr_ph && dec_reg.op == ABC_OP_BITCLR;
    always_comb begin
        w_next   = and_to_w ? res_reg : w_reg;
        z_next   = (wr_ph && dec_reg.op == ABC_OP_AND) ?
                   (res_reg == 8'h00) : z_reg;
        fwr_next.we   = and_to_f || clr_to_f;
        fwr_next.addr = dec_reg.faddr;
        fwr_next.data = res_reg;
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            dec_reg   <= '0;
            fwr_reg   <= '0;
            raddr_reg <= 8'h00;
            opnd_reg  <= 8'h00;
            res_reg   <= 8'h00;
            w_reg     <= `ABC_W_RESET;
            z_reg     <= `ABC_Z_RESET;
            ph_reg    <= 2'h0;
            busy_reg  <= 1'b0;
        end else begin
            dec_reg   <= dec_next;
            fwr_reg   <= fwr_next;
            // Q2 read: address held during Q2, operand latched at its end
            raddr_reg <= (q == ABC_Q1) ? instr[7:0] : raddr_reg;
            opnd_reg  <= (q == ABC_Q2) ? file_rdata : opnd_reg;
            res_reg   <= res_next;
            w_reg     <= w_next;
            z_reg     <= z_next;
            ph_reg    <= q;
            busy_reg  <= dec_next.op != ABC_OP_NONE;
        end
    end

    assign file_raddr       = raddr_reg;
    assign file_we          = fwr_reg.we;
    assign file_waddr       = fwr_reg.addr;
    assign file_wdata       = fwr_reg.data;
    assign working_register = w_reg;
    assign zero_flag        = z_reg;
    assign phase            = ph_reg;
    assign busy_and         = busy_reg;
endmodule

// >>> tb/abc_exec_props.sv
// Checker for abc_exec write-back, flags and read address.
// Assumes the first edge after reset release is a Q1 edge.
`timescale 1ns/1ps
module abc_exec_props (
    // Clock and reset
    input wire logic        clock,
    input wire logic        rstn,
    // Observed ports
    input wire logic        instr_valid,
    input wire logic [15:0] instr,
    input wire logic [7:0]  file_raddr,
    input wire logic [7:0]  file_rdata,
    input wire logic        file_we,
    input wire logic [7:0]  file_waddr,
    input wire logic [7:0]  file_wdata,
    input wire logic [7:0]  working_register,
    input wire logic        zero_flag
);
    logic [1:0]  q_reg;
    logic [15:0] cap_reg;
    logic        capv_reg;
    logic [7:0]  rd_reg;
    wire is_and = capv_reg && cap_reg[15:9] == 7'h05;
    wire is_clr = capv_reg && cap_reg[15:11] == 5'h11;
    wire wr_f   = is_clr || (is_and && cap_reg[8]);
    wire q1     = q_reg == 2'h0;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // Own phase count, since the phase port lags a cycle
    always_ff @(posedge clock) begin
        if (!rstn) q_reg <= 2'h0;
        else q_reg <= q_reg + 2'h1;
    end
    always_ff @(posedge clock) begin
        if (q1) cap_reg <= instr;
        if (q1) capv_reg <= instr_valid && rstn;
        if (q_reg == 2'h1) rd_reg <= file_rdata;
    end
    sequence s_q1; q1 && instr_valid; endsequence
    sequence s_wb; q1 && wr_f; endsequence
    a_we_slot: assert property (file_we |-> s_wb)
        else $error("file write outside its slot");
    a_we_owed: assert property (s_wb |-> file_we)
        else $error("file write missing");
    a_read_addr: assert property (
        s_q1 |=> file_raddr == cap_reg[7:0])
        else $error("read address wrong");
    a_write_addr: assert property (
        file_we |-> file_waddr == cap_reg[7:0])
        else $error("write address wrong");
    a_write_data: assert property (
        file_we |-> file_wdata == (is_clr ?
        rd_reg & ~(8'h01 << cap_reg[10:8]) : working_register & rd_reg))
        else $error("write data wrong");
    a_work_update: assert property (
        q1 && is_and && !cap_reg[8] |->
        working_register == ($past(working_register) & rd_reg))
        else $error("working register wrong");
    a_zero_value: assert property (
        q1 && is_and |->
        zero_flag == (($past(working_register) & rd_reg) == 8'h00))
        else $error("zero flag wrong");
    a_zero_hold: assert property (
        !(q1 && is_and) |-> $stable(zero_flag))
        else $error("zero flag moved");
endmodule

// >>> tb/tb_abc_exec.sv
// Bench for abc_exec: one instruction then a four-clock gap.
// Assumes the write-back lands within that gap.
`timescale 1ns/1ps
module tb_abc_exec;
    logic        clock, rstn, instr_valid, file_we, zero_flag, got_we;
    logic        busy_and;
    logic [1:0]  phase;
    logic [15:0] instr;
    logic [7:0]  file_raddr, file_rdata, file_waddr, file_wdata, ga, gd;
    logic [7:0]  working_register;
    int          n_errors = 0;
    int          tests_run = 0;
    int          we_cnt = 0;
    abc_exec dut (.clock, .rstn, .instr_valid, .instr, .file_raddr,
        .file_rdata, .file_we, .file_waddr, .file_wdata, .working_register,
        .zero_flag, .phase, .busy_and);
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // Counting strobes keeps got_we owned by the stimulus process alone
    always @(posedge clock) if (file_we) begin
        we_cnt <= we_cnt + 1;
        ga <= file_waddr;
        gd <= file_wdata;
    end
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            n_errors++;
        end
    endtask
    task go(input logic [15:0] i, input logic v, input logic [7:0] rd);
        int   base;
        logic dec;
        base = we_cnt;
        dec = v && (i[15:9] == 7'h05 || i[15:11] == 5'h11);
        instr = i;
        instr_valid = v;
        file_rdata = rd;
        @(negedge clock);
        if (v) chk("raddr", i[7:0], file_raddr);
        chk("phase", 8'h00, 8'(phase));
        chk("busy", 8'(dec), 8'(busy_and));
        repeat (3) @(negedge clock);
        instr_valid = 1'b0;
        repeat (4) @(negedge clock);
        got_we = (we_cnt != base);
    endtask
    task t_clr;
        for (int b = 0; b < 8; b++) begin
            go({5'h11, 3'(b), b[0] ? 8'hFF : 8'h00}, 1'b1, 8'hC7);
            chk("we", 8'h01, 8'(got_we));
            chk("wdata", 8'hC7 & ~(8'h01 << b), gd);
            chk("waddr", b[0] ? 8'hFF : 8'h00, ga);
            chk("zero", 8'h00, 8'(zero_flag));
        end
        $display("t_clr done");
    endtask
    task t_and;
        go({7'h05, 1'b1, 8'h3C}, 1'b1, 8'hC2);
        chk("we", 8'h01, 8'(got_we));
        chk("waddr", 8'h3C, ga);
        chk("wdata", 8'h00, gd);
        go({7'h05, 1'b0, 8'h81}, 1'b1, 8'hFF);
        chk("we", 8'h00, 8'(got_we));
        chk("work", 8'h00, working_register);
        chk("zero", 8'h01, 8'(zero_flag));
        $display("t_and done");
    endtask
    task t_bad;
        go(16'h0E3C, 1'b1, 8'hFF);
        chk("we", 8'h00, 8'(got_we));
        go({5'h11, 3'h2, 8'h10}, 1'b0, 8'hFF);
        chk("we", 8'h00, 8'(got_we));
        chk("zero", 8'h01, 8'(zero_flag));
        $display("t_bad done");
    endtask
    task complete_run;
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        rstn = 1'b0;
        instr_valid = 1'b0;
        instr = 16'h0000;
        file_rdata = 8'h00;
        got_we = 1'b0;
        repeat (16) @(negedge clock);
        rstn = 1'b1;
        t_clr();
        t_and();
        t_bad();
        complete_run();
    end
endmodule
bind abc_exec abc_exec_props u_props (.clock, .rstn, .instr_valid, .instr,
    .file_raddr, .file_rdata, .file_we, .file_waddr, .file_wdata,
    .working_register, .zero_flag);
